// [asb_pkg.sv]
// package for the async sram byte port controller
package asb_pkg;
   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   // ------------------------------------------------------------
   // timing, ns as printed, cycles derived at 100 MHz
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS              = 10;
   localparam int CYCLE_TIME_NS              = 85;   // read and write cycle time
   localparam int SELECT_TO_WRITE_END_NS     = 75;
   localparam int DATA_SETUP_TO_WRITE_END_NS = 40;
   localparam int WRITE_RECOVERY_TIME_NS     = 10;
   localparam int WRITE_TO_FLOAT_TIME_NS     = 30;
   localparam int OUTPUT_ACTIVE_AFTER_WR_NS  = 5;
   localparam int OUTPUT_HOLD_NS             = 5;
   // least times round up, none below one cycle
   function automatic int ceil_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int ACCESS_CYC     = ceil_cyc(CYCLE_TIME_NS);
   localparam int WRITE_LOW_CYC  = ceil_cyc(SELECT_TO_WRITE_END_NS);
   localparam int DATA_SETUP_CYC = ceil_cyc(DATA_SETUP_TO_WRITE_END_NS);
   localparam int RECOVERY_CYC   = ceil_cyc(WRITE_RECOVERY_TIME_NS);
   localparam int FLOAT_CYC      = ceil_cyc(WRITE_TO_FLOAT_TIME_NS);
   localparam int HOLD_CYC       = ceil_cyc(OUTPUT_HOLD_NS);
   localparam int CNT_W          = 4;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] word_address;
      logic [DATA_W-1:0] wdata;
   } asb_req_t;
   typedef struct packed {
      logic              select_n;
      logic              write_strobe_n;
      logic              output_gate_n;
   } asb_strobe_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_WRITE, ST_RECOVER, ST_READ, ST_HOLD
   } asb_state_t;
endpackage

// [asb_sram_ctrl.sv]
// controller that sequences strobes of an asynchronous 32k x 8 static memory
// Notes on behaviour
// - address and select stable 75 ns before end
// - data valid 40 ns before write end
// - 10 ns recovery after strobe rises
// - never drive against device's read data
// - retention mode lets inputs float
// - strobe high whenever address changes
`timescale 1ns/1ps
module asb_sram_ctrl #(
   parameter int ACCESS_CYC     = asb_pkg::ACCESS_CYC,
   parameter int WRITE_LOW_CYC  = asb_pkg::WRITE_LOW_CYC,
   parameter int DATA_SETUP_CYC = asb_pkg::DATA_SETUP_CYC,
   parameter int RECOVERY_CYC   = asb_pkg::RECOVERY_CYC,
   parameter int FLOAT_CYC      = asb_pkg::FLOAT_CYC
) (
   input  wire logic                         clock,
   input  wire logic                         rst,
   input  wire logic                         req_valid,
   input  wire asb_pkg::asb_req_t            req,
   output logic                              req_ready,
   output logic                              rsp_valid,
   output logic [asb_pkg::DATA_W-1:0]        rsp_rdata,
   input  wire logic                         retention,
   output logic [asb_pkg::ADDR_W-1:0]        word_address,
   output asb_pkg::asb_strobe_t              strobes,
   output logic [asb_pkg::DATA_W-1:0]        byte_bus_out,
   output logic                              byte_bus_oe_n,
   input  wire logic [asb_pkg::DATA_W-1:0]   byte_bus_in
);
   // ------------------------------------------------------------
   // state and counters
   // ------------------------------------------------------------
   asb_pkg::asb_state_t              state_q;
   logic [asb_pkg::CNT_W-1:0]        cnt_q;
   logic                             wr_q;
   logic                             accept;
   logic [asb_pkg::CNT_W-1:0]        write_low_c;
   logic [asb_pkg::CNT_W-1:0]        float_c;
   logic [asb_pkg::CNT_W-1:0]        access_c;
   logic [asb_pkg::CNT_W-1:0]        recover_c;

   // cycle budget at the default counts, counted from the accepting edge:
   // a write spends 3 cycles selected with the gate high, 8 with the
   // strobe low and our data on the bus, 1 of recovery, then 1 of hold;
   // a read spends 9 selected with the gate low, then 1 of hold.
   // every count rounds up, so each phase is at least its least time;
   // the price is up to 5 ns of slack per phase at this clock rate.

   // strobe held low for the longer of select-to-end and data setup
   assign write_low_c = asb_pkg::CNT_W'((WRITE_LOW_CYC > DATA_SETUP_CYC) ?
                                        WRITE_LOW_CYC : DATA_SETUP_CYC);
   assign float_c     = asb_pkg::CNT_W'(FLOAT_CYC);
   assign access_c    = asb_pkg::CNT_W'(ACCESS_CYC);
   assign recover_c   = asb_pkg::CNT_W'(RECOVERY_CYC);
   // no new request while the pins hold retention
   assign accept = req_valid && req_ready && !retention;

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   // one request at a time; address moves only with the strobe high
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= asb_pkg::ST_IDLE;
         cnt_q   <= '0;
         wr_q    <= 1'b0;
      end else begin
         case (state_q)
            asb_pkg::ST_IDLE: begin
               cnt_q <= '0;
               if (accept) begin
                  wr_q    <= req.write;
                  state_q <= req.write ? asb_pkg::ST_SETUP : asb_pkg::ST_READ;
               end
            end
            // gate raised and select low a while before strobe falls, so
            // our drive never meets device output
            asb_pkg::ST_SETUP: begin
               if (cnt_q + 1'b1 >= float_c) begin
                  cnt_q   <= '0;
                  state_q <= asb_pkg::ST_WRITE;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            // strobe low phase covers both select and data setup
            asb_pkg::ST_WRITE: begin
               if (cnt_q + 1'b1 >= write_low_c) begin
                  cnt_q   <= '0;
                  state_q <= asb_pkg::ST_RECOVER;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            // recovery counted from the strobe rising
            asb_pkg::ST_RECOVER: begin
               if (cnt_q + 1'b1 >= recover_c) begin
                  cnt_q   <= '0;
                  state_q <= asb_pkg::ST_HOLD;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            // full access time before the byte is taken
            asb_pkg::ST_READ: begin
               if (cnt_q + 1'b1 >= access_c) begin
                  cnt_q   <= '0;
                  state_q <= asb_pkg::ST_HOLD;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            // turnaround before the next request may be taken
            asb_pkg::ST_HOLD: begin
               state_q <= asb_pkg::ST_IDLE;
            end
            default: state_q <= asb_pkg::ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   // select high outside a cycle; in retention inputs are left alone
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         strobes      <= '{select_n: 1'b1, write_strobe_n: 1'b1, output_gate_n: 1'b1};
         word_address <= '0;
         byte_bus_out <= '0;
      end else begin
         case (state_q)
            asb_pkg::ST_IDLE: begin
               strobes.write_strobe_n <= 1'b1;
               strobes.output_gate_n  <= 1'b1;
               strobes.select_n       <= !(accept);
               if (accept) begin
                  word_address          <= req.word_address;
                  byte_bus_out          <= req.wdata;
                  strobes.output_gate_n <= req.write;
               end
            end
            // strobe falls only after the gate has been high a while
            asb_pkg::ST_SETUP: begin
               if (cnt_q + 1'b1 >= float_c) begin
                  strobes.write_strobe_n <= 1'b0;
               end
            end
            // strobe rises first; select follows after recovery
            asb_pkg::ST_WRITE: begin
               if (cnt_q + 1'b1 >= write_low_c) begin
                  strobes.write_strobe_n <= 1'b1;
               end
            end
            // deselect ends the write cycle
            asb_pkg::ST_RECOVER: begin
               if (cnt_q + 1'b1 >= recover_c) begin
                  strobes.select_n <= 1'b1;
               end
            end
            // gate and select rise together once the byte is taken
            asb_pkg::ST_READ: begin
               if (cnt_q + 1'b1 >= access_c) begin
                  strobes.select_n      <= 1'b1;
                  strobes.output_gate_n <= 1'b1;
               end
            end
            // one idle cycle lets the device float the bus
            asb_pkg::ST_HOLD: begin
               strobes.select_n <= 1'b1;
            end
            default: strobes.select_n <= 1'b1;
         endcase
      end
   end

   // our bus drive spans the write only; zero data hold lets it drop late
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         byte_bus_oe_n <= 1'b1;
      end else if (state_q == asb_pkg::ST_SETUP && cnt_q + 1'b1 >= float_c) begin
         byte_bus_oe_n <= 1'b0;
      end else if (state_q == asb_pkg::ST_RECOVER && cnt_q + 1'b1 >= recover_c) begin
         byte_bus_oe_n <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // handshake and read capture
   // ------------------------------------------------------------
   // sample at end of access, before deselect can float the bus
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         req_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (accept) begin
            req_ready <= 1'b0;
         end else if (state_q == asb_pkg::ST_HOLD) begin
            req_ready <= 1'b1;
         end
         if (state_q == asb_pkg::ST_READ && cnt_q + 1'b1 >= access_c) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= byte_bus_in;
         end else if (state_q == asb_pkg::ST_RECOVER && cnt_q + 1'b1 >= recover_c) begin
            rsp_valid <= wr_q;  // write completion, readable next
         end
      end
   end
endmodule // asb_sram_ctrl

// [asb_sram_ctrl_sva.sv]
// checker for the async sram byte port controller
`timescale 1ns/1ps
module asb_sram_ctrl_sva #(
   parameter int ACCESS_CYC    = 9,
   parameter int WRITE_LOW_CYC = 8
) (
   input wire logic                 clock,
   input wire logic                 rst,
   input wire logic                 req_valid,
   input wire asb_pkg::asb_req_t    req,
   input wire logic                 req_ready,
   input wire logic                 rsp_valid,
   input wire logic                 retention,
   input wire logic [14:0]          word_address,
   input wire asb_pkg::asb_strobe_t strobes,
   input wire logic [7:0]           byte_bus_out,
   input wire logic                 byte_bus_oe_n
);
   int low_q;
   int sel_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // run lengths of strobe low and select low
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         low_q <= 0;
         sel_q <= 0;
      end else begin
         low_q <= strobes.write_strobe_n ? 0 : low_q + 1;
         sel_q <= strobes.select_n ? 0 : sel_q + 1;
      end
   end
   a_strobe_width: assert property ($rose(strobes.write_strobe_n) |-> low_q == WRITE_LOW_CYC)
      else $error("write strobe width wrong");
   a_addr_held: assert property (!strobes.write_strobe_n |-> $stable(word_address) && !strobes.select_n)
      else $error("address or select moved in write");
   a_write_setup: assert property (req_valid && req_ready && !retention && req.write
      |=> (strobes.write_strobe_n && !strobes.select_n) [*3] ##1 !strobes.write_strobe_n)
      else $error("write setup wrong");
   a_data_setup: assert property ($fell(strobes.write_strobe_n) |-> (!byte_bus_oe_n && $stable(byte_bus_out)) [*4])
      else $error("write data not held");
   a_write_recovery: assert property ($rose(strobes.write_strobe_n) |-> !strobes.select_n ##1 strobes.select_n)
      else $error("recovery wrong");
   a_no_clash: assert property (!byte_bus_oe_n |-> strobes.output_gate_n)
      else $error("bus driven against device");
   a_addr_strobe: assert property (!$stable(word_address) |-> strobes.write_strobe_n)
      else $error("address moved with strobe low");
   a_retain_idle: assert property (retention && req_ready |=> strobes.select_n)
      else $error("selected in retention");
   a_read_wait: assert property ($rose(rsp_valid) |-> sel_q >= ACCESS_CYC)
      else $error("answer before access time");
endmodule // asb_sram_ctrl_sva
bind asb_sram_ctrl asb_sram_ctrl_sva #(.ACCESS_CYC(ACCESS_CYC), .WRITE_LOW_CYC(WRITE_LOW_CYC)) u_sva (
   .clock(clock), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
   .rsp_valid(rsp_valid), .retention(retention), .word_address(word_address), .strobes(strobes),
   .byte_bus_out(byte_bus_out), .byte_bus_oe_n(byte_bus_oe_n));

// [asb_sram_model.sv]
// behavioural model of the 32k x 8 static memory on the far side
`timescale 1ns/1ps
module asb_sram_model (
   input wire logic [14:0]          word_address,
   input wire asb_pkg::asb_strobe_t strobes,
   input wire logic [7:0]           byte_bus_out,
   input wire logic                 byte_bus_oe_n,
   output logic [7:0]               byte_bus_in
);
   logic [7:0] mem [0:32767];
   logic [7:0] last_q;
   logic [7:0] drv_val;
   logic       drive;
   // device drives only when selected, gated and not writing
   assign drive = !strobes.select_n && !strobes.output_gate_n && strobes.write_strobe_n;
   // byte taken when the overlap ends; deselect blocks every input
   always @(posedge (strobes.select_n | strobes.write_strobe_n))
      mem[word_address] <= byte_bus_in;
   assign drv_val = !byte_bus_oe_n ? byte_bus_out : mem[word_address];
   always @(drv_val or drive or byte_bus_oe_n)
      if (drive || !byte_bus_oe_n) last_q = drv_val;
   // no pull on the bus: a floating bus shows the inverse of the last level
   assign byte_bus_in = (drive && !byte_bus_oe_n) ? 8'hXX :
                        (drive || !byte_bus_oe_n) ? drv_val : ~last_q;
endmodule // asb_sram_model

// [tb_asb_sram_ctrl.sv]
// testbench for the async sram byte port controller
`timescale 1ns/1ps
module tb_asb_sram_ctrl;
   logic                 clock, rst, req_valid, retention, req_ready, rsp_valid, byte_bus_oe_n;
   asb_pkg::asb_req_t    req;
   asb_pkg::asb_strobe_t strobes;
   logic [7:0]           rsp_rdata, byte_bus_out, byte_bus_in;
   logic [14:0]          word_address;
   int                   bad_count, n_compared, lat;
   asb_sram_ctrl dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retention(retention),
      .word_address(word_address), .strobes(strobes), .byte_bus_out(byte_bus_out),
      .byte_bus_oe_n(byte_bus_oe_n), .byte_bus_in(byte_bus_in));
   asb_sram_model mem (.word_address(word_address), .strobes(strobes),
      .byte_bus_out(byte_bus_out), .byte_bus_oe_n(byte_bus_oe_n), .byte_bus_in(byte_bus_in));
   initial begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask
   // one request, held until taken; lat counts cycles from accept to answer
   task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req_valid = 1;
      req = '{w, a, d};
      while (req_ready !== 1'b1 && n < 100) begin
         @(posedge clock); #1 n++;
      end
      @(posedge clock); #1 req_valid = 0;
      lat = 1;
      while (rsp_valid !== 1'b1 && lat < 100) begin
         @(posedge clock); #1 lat++;
      end
      // a limit that runs out is a failure in its own right
      if (n >= 100 || lat >= 100) begin
         bad_count++;
         $display("wrong value at %0t: transfer timed out", $time);
      end
   endtask
   // pins and handshake at their idle levels, as after any reset
   task automatic chk_idle(input string msg);
      chk({5'h00, strobes}, 8'h07, msg);
      chk({5'h00, rsp_valid, req_ready, byte_bus_oe_n}, 8'h03, msg);
      chk({6'h00, |word_address, |byte_bus_out}, 8'h00, msg);
   endtask
   // reset cut into a read: pins drop at once and the port works again
   task automatic test_reset;
      chk_idle("idle after first reset");
      req_valid = 1;
      req = '{1'b0, 15'h0002, 8'h00};
      @(posedge clock); #1 req_valid = 0;
      repeat (3) @(posedge clock);
      #1 rst = 1;
      #1 chk_idle("idle in reset");
      @(posedge clock); #1 rst = 0;
      @(posedge clock); #1 chk_idle("idle after cut read");
      xfer(1, 15'h0006, 8'h96);
      xfer(0, 15'h0006, 8'h00);
      chk(rsp_rdata, 8'h96, "after mid-run reset");
      $display("test_reset done");
   endtask
   task automatic test_fill;
      logic [14:0] a[4] = '{15'h0000, 15'h7FFF, 15'h2AAA, 15'h5555};
      logic [7:0]  d[4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
      for (int i = 0; i < 4; i++) begin
         xfer(1, a[i], d[i]);
         chk(8'(lat), 8'h0D, "write latency");
      end
      for (int i = 0; i < 4; i++) begin
         xfer(0, a[i], 8'h00);
         chk(8'(lat), 8'h0A, "read latency");
         chk(rsp_rdata, d[i], "read back");
      end
      $display("test_fill done");
   endtask
   task automatic test_overwrite;
      xfer(1, 15'h0001, 8'h11);
      xfer(1, 15'h0001, 8'h22);
      xfer(0, 15'h0001, 8'h00);
      chk(rsp_rdata, 8'h22, "last write wins");
      $display("test_overwrite done");
   endtask
   task automatic test_retention;
      retention = 1;
      req_valid = 1;
      req = '{1'b1, 15'h0003, 8'h3C};
      repeat (20) begin
         @(posedge clock); #1 chk({7'h00, strobes.select_n}, 8'h01, "select in retention");
      end
      retention = 0;
      xfer(1, 15'h0004, 8'hC3);
      xfer(0, 15'h0004, 8'h00);
      chk(rsp_rdata, 8'hC3, "after retention");
      $display("test_retention done");
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000 bad_count++;
      finish_test();
   end
   initial begin
      rst = 1; req_valid = 0; retention = 0; req = '0;
      bad_count = 0; n_compared = 0;
      repeat (6) @(posedge clock);
      #1 rst = 0;
      @(posedge clock); #1 test_reset();
      test_fill();
      test_overwrite();
      test_retention();
      finish_test();
   end
endmodule // tb_asb_sram_ctrl
